// ===== lia_regs.svh
// Offsets, field positions and reset values of the indirect access bank
`ifndef LIA_REGS_SVH
`define LIA_REGS_SVH

// ---------------------------------------------------------------
// Direct register addresses
// ---------------------------------------------------------------
`define LIA_ADDR_DATA 8'hD2
`define LIA_ADDR_PTR 8'hD3

// ---------------------------------------------------------------
// Indirect indices
// ---------------------------------------------------------------
`define LIA_IDX_BUF_HI_MASK 8'hF8
`define LIA_IDX_CTRL 8'h08
`define LIA_IDX_ERR 8'h0A

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define LIA_CTRL_STOP 7
`define LIA_CTRL_DACK 4
`define LIA_CTRL_RSTERR 2
`define LIA_CTRL_MASK 8'h90

// ---------------------------------------------------------------
// Error register fields
// ---------------------------------------------------------------
`define LIA_ERR_SYNC 4
`define LIA_ERR_PARITY_ERROR 3
`define LIA_ERR_TIMEOUT_ERROR 2
`define LIA_ERR_CHK 1
`define LIA_ERR_BIT 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define LIA_RST_PTR 8'h00
`define LIA_RST_CTRL 8'h00
`define LIA_RST_ERR 5'h00
`define LIA_RST_BYTE 8'h00

`endif

// ===== lia_pkg.sv
// Types shared by the indirect access bank
package lia_pkg;
    typedef logic [7:0] lia_byte_t;
    typedef logic [2:0] lia_bidx_t;

    // Source of a pending host read
    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_PTR = 3'h1,
        SRC_BUF = 3'h3,
        SRC_CTRL = 3'h2,
        SRC_ERR = 3'h6,
        SRC_ZERO = 3'h7
    } lia_src_e;

    typedef struct packed {
        lia_byte_t ptr;
        lia_byte_t ctrl;
        logic [4:0] err;
        logic rxSync1;
        logic rxSync2;
        lia_src_e rdSrc;
        lia_byte_t rdata;
        logic rvalid;
    } lia_state_s;

    typedef struct packed {
        lia_byte_t [7:0] mem;
        lia_byte_t rdata;
    } lia_mem_s;
endpackage

// ===== lia_buf_mem.sv
// Eight-byte frame data buffer with registered read data
`timescale 1ns/1ps
module lia_buf_mem (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire lia_pkg::lia_bidx_t addr, // Byte index
    input wire logic we, // Write strobe
    input wire lia_pkg::lia_byte_t wdata, // Write data
    output lia_pkg::lia_byte_t rdata // Registered read data
);
    import lia_pkg::*;

    lia_mem_s st_q;
    lia_mem_s st_d;

    // Read before write; read data follow one edge later
    always_comb begin
        st_d = st_q;
        if (we) begin
            st_d.mem[addr] = wdata;
        end
        st_d.rdata = st_q.mem[addr];
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
endmodule

// ===== lia_top.sv
// Indirect access path and error status of the LIN controller
`timescale 1ns/1ps
`include "lia_regs.svh"
module lia_top (
    input wire logic sys_clk, // System clock, 40 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire lia_pkg::lia_byte_t sfrAddr, // Register address
    input wire logic sfrWe, // Write strobe
    input wire logic sfrRe, // Read strobe
    input wire lia_pkg::lia_byte_t sfrWdata, // Write data
    output lia_pkg::lia_byte_t sfrRdata, // Read data
    output logic sfrRvalid, // Read data valid pulse
    input wire logic masterMode, // Protocol engine acting as master
    input wire logic syncStb, // Sync field measured
    input wire logic syncBad, // Sync edges out of tolerance
    input wire logic idStb, // Identifier received
    input wire logic idParityBad, // Identifier parity failed
    input wire logic expectData, // Waiting for response bytes
    input wire logic noRespStb, // Response wait expired
    input wire logic frameOverStb, // Maximum frame length passed
    input wire logic firstByteStb, // First byte after identifier received
    input wire logic chkStb, // Checksum compare point
    input wire lia_pkg::lia_byte_t chkCalc, // Computed checksum
    input wire lia_pkg::lia_byte_t chkRecv, // Received checksum
    input wire logic txActive, // Transmitter driving the bus
    input wire logic txBit, // Level being driven
    input wire logic bitStb, // Bus sample point
    input wire logic rxPin, // Bus receive pin, asynchronous
    output logic ctrlStop, // Stop request to protocol engine
    output logic ctrlDack, // Data acknowledge to protocol engine
    output logic [4:0] errFlags // Error flags to protocol engine
);
    import lia_pkg::*;

    lia_state_s st_q;
    lia_state_s st_d;
    lia_byte_t bufRdata;
    logic dataWr;
    logic dataRd;
    logic bufHit;
    logic errClr;
    logic [4:0] errSet;

    // ---------------------------------------------------------------
    // Decode of host accesses
    // ---------------------------------------------------------------
    assign dataWr = sfrWe && (sfrAddr == `LIA_ADDR_DATA);
    assign dataRd = sfrRe && (sfrAddr == `LIA_ADDR_DATA);
    assign bufHit = (st_q.ptr & `LIA_IDX_BUF_HI_MASK) == 8'h00;
    assign errClr = dataWr && (st_q.ptr == `LIA_IDX_CTRL) && sfrWdata[`LIA_CTRL_RSTERR];

    // ---------------------------------------------------------------
    // Error event detection
    // ---------------------------------------------------------------
    always_comb begin
        errSet = 5'h00;
        errSet[`LIA_ERR_SYNC] = syncStb && syncBad && !masterMode;
        errSet[`LIA_ERR_PARITY_ERROR] = idStb && idParityBad && !masterMode;
        errSet[`LIA_ERR_TIMEOUT_ERROR] = (expectData && noRespStb)
            || frameOverStb
            || (firstByteStb && !st_q.ctrl[`LIA_CTRL_DACK]
                && !st_q.ctrl[`LIA_CTRL_STOP]);
        errSet[`LIA_ERR_CHK] = chkStb && (chkCalc != chkRecv);
        errSet[`LIA_ERR_BIT] = bitStb && txActive && (txBit != st_q.rxSync2);
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rxSync1 = rxPin;
        st_d.rxSync2 = st_q.rxSync1;
        // Pointer written directly
        if (sfrWe && (sfrAddr == `LIA_ADDR_PTR)) begin
            st_d.ptr = sfrWdata;
        end
        // Control written through the data register; reset bit self-clears
        if (dataWr && (st_q.ptr == `LIA_IDX_CTRL)) begin
            st_d.ctrl = sfrWdata & `LIA_CTRL_MASK;
        end
        // Set wins over clear; host writes to the error index are dropped
        st_d.err = (st_q.err & ~{5{errClr}}) | errSet;
        // First read stage selects the source
        st_d.rdSrc = SRC_NONE;
        if (sfrRe && (sfrAddr == `LIA_ADDR_PTR)) begin
            st_d.rdSrc = SRC_PTR;
        end else if (dataRd) begin
            if (bufHit) begin
                st_d.rdSrc = SRC_BUF;
            end else if (st_q.ptr == `LIA_IDX_CTRL) begin
                st_d.rdSrc = SRC_CTRL;
            end else if (st_q.ptr == `LIA_IDX_ERR) begin
                st_d.rdSrc = SRC_ERR;
            end else begin
                st_d.rdSrc = SRC_ZERO;
            end
        end
        // Second read stage drives the answer
        st_d.rvalid = st_q.rdSrc != SRC_NONE;
        case (st_q.rdSrc)
            SRC_PTR: st_d.rdata = st_q.ptr;
            SRC_BUF: st_d.rdata = bufRdata;
            SRC_CTRL: st_d.rdata = st_q.ctrl;
            SRC_ERR: st_d.rdata = {3'h0, st_q.err};
            SRC_ZERO: st_d.rdata = 8'h00;
            SRC_NONE: st_d.rdata = st_q.rdata;
            default: st_d.rdata = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q.ptr <= `LIA_RST_PTR;
            st_q.ctrl <= `LIA_RST_CTRL;
            st_q.err <= `LIA_RST_ERR;
            st_q.rxSync1 <= 1'b1;
            st_q.rxSync2 <= 1'b1;
            st_q.rdSrc <= SRC_NONE;
            st_q.rdata <= `LIA_RST_BYTE;
            st_q.rvalid <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Frame data buffer at indices 0x00 to 0x07
    lia_buf_mem i_lia_buf_mem (
        .sys_clk(sys_clk),
        .rst(rst),
        .addr(st_q.ptr[2:0]),
        .we(dataWr && bufHit),
        .wdata(sfrWdata),
        .rdata(bufRdata)
    );

    // Outputs from flip-flops
    assign sfrRdata = st_q.rdata;
    assign sfrRvalid = st_q.rvalid;
    assign ctrlStop = st_q.ctrl[`LIA_CTRL_STOP];
    assign ctrlDack = st_q.ctrl[`LIA_CTRL_DACK];
    assign errFlags = st_q.err;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence seqPtrRead;
        sfrRe && (sfrAddr == `LIA_ADDR_PTR) && !sfrWe;
    endsequence

    sequence seqDataRead;
        dataRd && !sfrWe && (errSet == 5'h00) && !$past(sfrWe);
    endsequence

    AST_PTR_READBACK: assert property (seqPtrRead |-> ##2 sfrRvalid && (sfrRdata == $past(st_q.ptr, 2)))
        else $error("pointer read back wrong");

    AST_BUF_READ: assert property (seqDataRead and bufHit |-> ##2 sfrRvalid && (sfrRdata == $past(bufRdata, 1)))
        else $error("buffer read wrong");

    AST_CTRL_WRITE: assert property (dataWr && (st_q.ptr == `LIA_IDX_CTRL) |=> ctrlStop == $past(sfrWdata[7]) && ctrlDack == $past(sfrWdata[4]))
        else $error("control write lost");

    AST_ERR_READ: assert property (seqDataRead and (st_q.ptr == `LIA_IDX_ERR) |-> ##2 sfrRvalid && (sfrRdata == {3'h0, $past(st_q.err, 1)}))
        else $error("error register read wrong");

    AST_ERR_CLEAR: assert property (errClr && (errSet == 5'h00) |=> errFlags == 5'h00)
        else $error("error flags not cleared");

    AST_SET_WINS: assert property (errClr && (errSet != 5'h00) |=> errFlags == $past(errSet))
        else $error("new error lost to a clear");

    AST_ERR_RO: assert property (dataWr && (st_q.ptr == `LIA_IDX_ERR) && (errSet == 5'h00) |=> $stable(errFlags))
        else $error("error register changed by write");

    AST_SYNC_SLAVE: assert property ($rose(errFlags[`LIA_ERR_SYNC]) |-> $past(syncStb && syncBad && !masterMode))
        else $error("sync error set without cause");

    AST_PARITY: assert property (idStb && idParityBad && !masterMode |=> errFlags[`LIA_ERR_PARITY_ERROR])
        else $error("parity error not flagged");

    AST_PARITY_MASTER: assert property ($rose(errFlags[`LIA_ERR_PARITY_ERROR]) |-> $past(!masterMode))
        else $error("parity error flagged in master mode");

    AST_TIMEOUT_ERROR_RESP: assert property (expectData && noRespStb |=> errFlags[`LIA_ERR_TIMEOUT_ERROR])
        else $error("response timeout not flagged");

    AST_TIMEOUT_ERROR_FRAME: assert property (frameOverStb ##1 1'b1 |-> errFlags[`LIA_ERR_TIMEOUT_ERROR])
        else $error("frame timeout not flagged");

    AST_TIMEOUT_ERROR_ACK: assert property (firstByteStb && !ctrlDack && !ctrlStop |=> errFlags[`LIA_ERR_TIMEOUT_ERROR])
        else $error("missing acknowledge not flagged");

    AST_CHK: assert property (chkStb && (chkCalc != chkRecv) |=> errFlags[`LIA_ERR_CHK] [*2] or errClr)
        else $error("checksum error not flagged");

    AST_BIT: assert property (bitStb && txActive && (txBit != st_q.rxSync2) |=> errFlags[`LIA_ERR_BIT])
        else $error("bit error not flagged");

    AST_UNMAPPED: assert property (seqDataRead and !bufHit && (st_q.ptr != `LIA_IDX_CTRL) && (st_q.ptr != `LIA_IDX_ERR) |-> ##2 sfrRvalid && (sfrRdata == 8'h00))
        else $error("unmapped index not zero");
endmodule

// ===== lia_host_model.sv
// Processor core model driving the register bus of the indirect access bank
`timescale 1ns/1ps
module lia_host_model (
    input wire logic sys_clk, // System clock
    output lia_pkg::lia_byte_t sfrAddr, // Register address
    output logic sfrWe, // Write strobe
    output logic sfrRe, // Read strobe
    output lia_pkg::lia_byte_t sfrWdata, // Write data
    input wire lia_pkg::lia_byte_t sfrRdata, // Read data
    input wire logic sfrRvalid // Read answer pulse
);
    import lia_pkg::*;
    initial begin
        sfrAddr = 8'h00;
        sfrWe = 1'b0;
        sfrRe = 1'b0;
        sfrWdata = 8'h00;
    end
    // One-cycle write; released lines show the inverse so stale values never pass
    task automatic wr(input lia_byte_t a, input lia_byte_t d);
        @(posedge sys_clk) #1;
        sfrAddr = a;
        sfrWdata = d;
        sfrWe = 1'b1;
        @(posedge sys_clk) #1;
        sfrWe = 1'b0;
        sfrAddr = ~a;
        sfrWdata = ~d;
    endtask
    // One-cycle read, then a bounded watch; lat counts edges after the read edge
    // Lat 7 means no answer, lat 6 means the answer stood more than one cycle
    task automatic rd(input lia_byte_t a, output lia_byte_t d, output logic [2:0] lat);
        @(posedge sys_clk) #1;
        sfrAddr = a;
        sfrRe = 1'b1;
        @(posedge sys_clk) #1;
        sfrRe = 1'b0;
        sfrAddr = ~a;
        lat = 3'h7;
        d = 8'h00;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) #1;
            if (sfrRvalid === 1'b1 && lat == 3'h7) begin
                lat = 3'(i + 1);
                d = sfrRdata;
            end else if (sfrRvalid === 1'b1) begin
                lat = 3'h6;
            end
        end
    endtask
endmodule

// ===== lia_top_bench.sv
// Self-checking bench for the indirect access bank and its error flags
`timescale 1ns/1ps
`include "lia_regs.svh"
`define CMP(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR at %0t: got %0h expected %0h", $time, got, exp); end end
module lia_top_bench;
    import lia_pkg::*;
    logic sys_clk;
    logic rst;
    logic [12:0] cs;
    logic rxPin;
    lia_byte_t chkRecv;
    lia_byte_t sfrAddr;
    lia_byte_t sfrWdata;
    lia_byte_t sfrRdata;
    logic sfrWe;
    logic sfrRe;
    logic sfrRvalid;
    logic ctrlStop;
    logic ctrlDack;
    logic [4:0] errFlags;
    int miscompares = 0;
    int checked = 0;
    // Event vector, received checksum, expected flags
    logic [25:0] tab [14] = '{
        {13'h0C00, 8'h3C, 5'h10}, {13'h0400, 8'h3C, 5'h00}, {13'h1C00, 8'h3C, 5'h00},
        {13'h0300, 8'h3C, 5'h08}, {13'h1300, 8'h3C, 5'h00},
        {13'h10C0, 8'h3C, 5'h04}, {13'h0040, 8'h3C, 5'h00}, {13'h00C0, 8'h3C, 5'h04},
        {13'h0020, 8'h3C, 5'h04}, {13'h0010, 8'h3C, 5'h04},
        {13'h0008, 8'h3D, 5'h02}, {13'h0008, 8'h3C, 5'h00},
        {13'h0005, 8'h3C, 5'h01}, {13'h0007, 8'h3C, 5'h00}};

    // ----------------------------------------------------------
    // Clock, reset and instances
    // ----------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    lia_host_model i_lia_host_model (.sys_clk(sys_clk), .sfrAddr(sfrAddr), .sfrWe(sfrWe),
        .sfrRe(sfrRe), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .sfrRvalid(sfrRvalid));
    lia_top i_lia_top (.sys_clk(sys_clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWe(sfrWe),
        .sfrRe(sfrRe), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .sfrRvalid(sfrRvalid),
        .masterMode(cs[12]), .syncStb(cs[11]), .syncBad(cs[10]), .idStb(cs[9]),
        .idParityBad(cs[8]), .expectData(cs[7]), .noRespStb(cs[6]), .frameOverStb(cs[5]),
        .firstByteStb(cs[4]), .chkStb(cs[3]), .chkCalc(8'h3C), .chkRecv(chkRecv),
        .txActive(cs[2]), .txBit(cs[1]), .bitStb(cs[0]), .rxPin(rxPin),
        .ctrlStop(ctrlStop), .ctrlDack(ctrlDack), .errFlags(errFlags));

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic rdc(input lia_byte_t a, input lia_byte_t e);
        lia_byte_t d;
        logic [2:0] lat;
        i_lia_host_model.rd(a, d, lat);
        `CMP(lat, 3'h1)
        `CMP(d, e)
    endtask
    task automatic wri(input lia_byte_t idx, input lia_byte_t d);
        i_lia_host_model.wr(`LIA_ADDR_PTR, idx);
        i_lia_host_model.wr(`LIA_ADDR_DATA, d);
    endtask
    task automatic rdi(input lia_byte_t idx, input lia_byte_t e);
        i_lia_host_model.wr(`LIA_ADDR_PTR, idx);
        rdc(`LIA_ADDR_PTR, idx);
        rdc(`LIA_ADDR_DATA, e);
    endtask
    // One-cycle pulse of the core-side event inputs
    task automatic pulse(input logic [12:0] v, input lia_byte_t r);
        @(posedge sys_clk) #1;
        cs = v;
        chkRecv = r;
        @(posedge sys_clk) #1;
        cs = 13'h0000;
        chkRecv = 8'h3C;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset();
        rdc(`LIA_ADDR_PTR, 8'h00);
        rdc(`LIA_ADDR_DATA, 8'h00);
        rdi(`LIA_IDX_ERR, 8'h00);
        `CMP({ctrlStop, ctrlDack, errFlags}, 7'h00)
    endtask
    task automatic t_buffer();
        for (int i = 0; i < 8; i++) wri(8'(i), 8'h5A ^ 8'(i));
        for (int i = 7; i >= 0; i--) rdi(8'(i), 8'h5A ^ 8'(i));
    endtask
    task automatic t_unmapped();
        wri(8'h09, 8'hFF);
        wri(8'hFF, 8'hFF);
        rdi(8'h09, 8'h00);
        rdi(8'hFF, 8'h00);
        rdi(8'h0B, 8'h00);
        rdi(8'h01, 8'h5B);
        rdi(8'h07, 8'h5D);
    endtask
    task automatic t_control();
        wri(`LIA_IDX_CTRL, 8'hFF);
        rdi(`LIA_IDX_CTRL, 8'h90);
        `CMP({ctrlStop, ctrlDack}, 2'h3)
        pulse(13'h0010, 8'h3C);
        wri(`LIA_IDX_CTRL, 8'h80);
        `CMP({ctrlStop, ctrlDack}, 2'h2)
        pulse(13'h0010, 8'h3C);
        wri(`LIA_IDX_CTRL, 8'h10);
        `CMP({ctrlStop, ctrlDack}, 2'h1)
        pulse(13'h0010, 8'h3C);
        `CMP(errFlags, 5'h00)
    endtask
    task automatic t_errors();
        logic [12:0] v;
        lia_byte_t r;
        logic [4:0] e;
        for (int i = 0; i < 14; i++) begin
            {v, r, e} = tab[i];
            wri(`LIA_IDX_CTRL, 8'h04);
            pulse(v, r);
            `CMP(errFlags, e)
            rdi(`LIA_IDX_ERR, {3'h0, e});
        end
        pulse(13'h0005, 8'h3C);
        wri(`LIA_IDX_ERR, 8'hFE);
        rdi(`LIA_IDX_ERR, 8'h01);
    endtask
    // Bus held low through the synchroniser, then a clear meeting a new error
    task automatic t_bitmon();
        wri(`LIA_IDX_CTRL, 8'h04);
        rxPin = 1'b0;
        repeat (3) @(posedge sys_clk);
        pulse(13'h0005, 8'h3C);
        `CMP(errFlags, 5'h00)
        pulse(13'h0007, 8'h3C);
        `CMP(errFlags, 5'h01)
        fork
            i_lia_host_model.wr(`LIA_ADDR_DATA, 8'h04);
            pulse(13'h0008, 8'h3D);
        join
        `CMP(errFlags, 5'h02)
        rxPin = 1'b1;
    endtask
    // Reset in mid-run returns every register to its reset value
    task automatic t_midreset();
        wri(8'h03, 8'hA5);
        wri(`LIA_IDX_CTRL, 8'h90);
        pulse(13'h0020, 8'h3C);
        rdc(`LIA_ADDR_PTR, `LIA_IDX_CTRL);
        @(posedge sys_clk) #1;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        `CMP({sfrRvalid, sfrRdata, ctrlStop, ctrlDack, errFlags}, 16'h0000)
        rdc(`LIA_ADDR_PTR, 8'h00);
        rdi(8'h03, 8'h00);
    endtask

    // ----------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ----------------------------------------------------------
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        cs = 13'h0000;
        chkRecv = 8'h3C;
        rxPin = 1'b1;
        repeat (16) @(posedge sys_clk);
        #1 rst = 1'b0;
        t_reset();
        t_buffer();
        t_unmapped();
        t_control();
        t_errors();
        t_bitmon();
        t_midreset();
        summarize();
    end
endmodule
